// file: loopback_code_defines.svh
`ifndef LOOPBACK_CODE_DEFINES_SVH
`define LOOPBACK_CODE_DEFINES_SVH

// register bus widths
`define LBC_ADDR_W            8
`define LBC_DATA_W            8

// register offsets (low byte of the channel address)
`define LBC_ENABLE_OFS        8'h21
`define LBC_STATUS_OFS        8'h22

// status field positions
`define LBC_BIT_ACT_PRESENT   3
`define LBC_BIT_DEACT_PRESENT 2
`define LBC_BIT_ACT_FLAG      1
`define LBC_BIT_DEACT_FLAG    0

// enable field positions
`define LBC_BIT_ACT_EN        1
`define LBC_BIT_DEACT_EN      0

// reset values
`define LBC_ENABLE_RESET      2'h0
`define LBC_STATUS_RESET      8'h00

// number of tracked codes
`define LBC_NUM_CODES         2

`endif

// file: loopback_code_pkg.sv
package loopback_code_pkg;

  // one byte of register data
  typedef logic [7:0] reg_byte_t;

  // code index; the value is the flag bit and the enable bit of that code
  typedef enum logic [0:0] {
    CODE_DEACT,
    CODE_ACT
  } code_sel_t;

  // per-code enable and flag vectors, indexed by code_sel_t
  typedef logic [1:0] code_vec_t;

endpackage

// file: code_change_if.sv
`timescale 1ns/1ns
// signals between the register logic and one code tracker
interface code_change_if;
  logic present;
  logic flag;
  logic change;
  logic clear;

  modport tracker (
    output present,
    output flag,
    output change,
    input  clear
  );

  modport ctrl (
    input  present,
    input  flag,
    input  change,
    output clear
  );
endinterface

// file: code_change_tracker.sv
`timescale 1ns/1ns
// follows one code: present state, change pulse and sticky change flag
module code_change_tracker (
  // clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      sys_rst_i,
  // detector side
  input  wire logic      match_i,
  input  wire logic      detect_en_i,
  // register side
  code_change_if.tracker link
);

  logic next_present;
  logic edge_seen;

  // presence counts only while detection of this code is enabled
  assign next_present = match_i & detect_en_i;
  assign edge_seen    = next_present ^ link.present;

  // present state register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link.present <= 1'b0;
    end else begin
      link.present <= next_present;
    end
  end

  // change on both the start and the end of detection
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link.change <= 1'b0;
    end else begin
      link.change <= edge_seen;
    end
  end

  // sticky flag; a new change beats a clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link.flag <= 1'b0;
    end else if (edge_seen) begin
      link.flag <= 1'b1;
    end else if (link.clear) begin
      link.flag <= 1'b0;
    end
  end

endmodule

// file: loopback_code_irq.sv
`timescale 1ns/1ns
`include "loopback_code_defines.svh"
// Contract
// - enable bit 1 gates activation change interrupt
// - enable bit 0 gates deactivation change interrupt
// - change event on detection start and stop
// - interrupt only when matching enable bit set
// - status bit 3 shows activation code present
// - status bit 2 shows deactivation code present
// - status bit 1 latches activation change, read clears
// - status bit 0 latches deactivation change, read clears
// - status bits 7-4, enable 7-2 reserved
module loopback_code_irq
  import loopback_code_pkg::*;
#(
  parameter int ADDR_W = `LBC_ADDR_W
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  // code detector
  input  wire logic              act_match_i,
  input  wire logic              act_detect_en_i,
  input  wire logic              deact_match_i,
  input  wire logic              deact_detect_en_i,
  // state toward the rest of the framer
  output logic                   act_code_present_o,
  output logic                   deact_code_present_o,
  output logic                   act_change_o,
  output logic                   deact_change_o,
  // interrupt request
  output logic                   irq_o
);

  // per-code links to the trackers
  code_change_if chg [`LBC_NUM_CODES] ();

  code_vec_t irq_en;
  code_vec_t flags;
  code_vec_t present;
  code_vec_t changes;
  code_vec_t clr;
  code_vec_t match_vec;
  code_vec_t det_en_vec;
  logic      sel_status;
  logic      sel_enable;
  reg_byte_t next_rdata;

  // address decode; only the two offsets answer
  assign sel_status = (addr_i == ADDR_W'(`LBC_STATUS_OFS));
  assign sel_enable = (addr_i == ADDR_W'(`LBC_ENABLE_OFS));

  // detector inputs ordered by code index
  assign match_vec[CODE_ACT]    = act_match_i;
  assign match_vec[CODE_DEACT]  = deact_match_i;
  assign det_en_vec[CODE_ACT]   = act_detect_en_i;
  assign det_en_vec[CODE_DEACT] = deact_detect_en_i;

  // clear by reading the status register, or by writing a one to the flag
  always_comb begin
    for (int i = 0; i < `LBC_NUM_CODES; i++) begin
      clr[i] = (rd_i & sel_status) | (wr_i & sel_status & wdata_i[i]);
    end
  end

  // one tracker per code
  generate
    for (genvar g = 0; g < `LBC_NUM_CODES; g++) begin : gen_code
      code_change_tracker u_tracker (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .match_i     (match_vec[g]),
        .detect_en_i (det_en_vec[g]),
        .link        (chg[g].tracker)
      );
      assign chg[g].clear = clr[g];
      assign flags[g]     = chg[g].flag;
      assign present[g]   = chg[g].present;
      assign changes[g]   = chg[g].change;
    end
  endgenerate

  // enable register; reserved bits 7-2 are not stored
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_en <= `LBC_ENABLE_RESET;
    end else if (wr_i && sel_enable) begin
      irq_en[`LBC_BIT_ACT_EN]   <= wdata_i[`LBC_BIT_ACT_EN];
      irq_en[`LBC_BIT_DEACT_EN] <= wdata_i[`LBC_BIT_DEACT_EN];
    end
  end

  // read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    next_rdata = `LBC_STATUS_RESET;
    if (sel_status) begin
      next_rdata[`LBC_BIT_ACT_PRESENT]   = present[CODE_ACT];
      next_rdata[`LBC_BIT_DEACT_PRESENT] = present[CODE_DEACT];
      next_rdata[`LBC_BIT_ACT_FLAG]      = flags[CODE_ACT];
      next_rdata[`LBC_BIT_DEACT_FLAG]    = flags[CODE_DEACT];
    end else if (sel_enable) begin
      next_rdata[`LBC_BIT_ACT_EN]        = irq_en[CODE_ACT];
      next_rdata[`LBC_BIT_DEACT_EN]      = irq_en[CODE_DEACT];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= `LBC_STATUS_RESET;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `LBC_STATUS_RESET;
    end
  end

  // level request; registered so the pin never glitches on a clear
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags & irq_en);
    end
  end

  // present and change copies toward the framer
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_code_present_o   <= 1'b0;
      deact_code_present_o <= 1'b0;
      act_change_o         <= 1'b0;
      deact_change_o       <= 1'b0;
    end else begin
      act_code_present_o   <= present[CODE_ACT];
      deact_code_present_o <= present[CODE_DEACT];
      act_change_o         <= changes[CODE_ACT];
      deact_change_o       <= changes[CODE_DEACT];
    end
  end

endmodule

// file: remote_code_source.sv
`timescale 1ns/1ns
// far end: puts loopback codes on the line
module remote_code_source (
  // clock and codes sent, bit 1 activation
  input  logic       ref_clk_i,
  input  logic [1:0] send_i,
  // what the detector sees
  output logic       act_match_o,
  output logic       deact_match_o
);
  // one cycle of line delay
  always_ff @(posedge ref_clk_i) begin
    act_match_o   <= send_i[1];
    deact_match_o <= send_i[0];
  end
endmodule

// file: loopback_code_irq_assertions.sv
`timescale 1ns/1ns
`include "loopback_code_defines.svh"
// flags sit inside, so irq is tied to change pulses and enable writes
module loopback_code_irq_assertions #(parameter int ADDR_W = `LBC_ADDR_W) (
  // clock, reset, bus
  input logic              ref_clk_i, sys_rst_i, wr_i, rd_i,
  input logic [ADDR_W-1:0] addr_i,
  input logic [7:0]        rdata_o,
  // detector and outputs
  input logic              act_match_i, act_detect_en_i, deact_match_i, deact_detect_en_i,
  input logic              act_code_present_o, deact_code_present_o,
  input logic              act_change_o, deact_change_o, irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  code_present_a: assert property (
    {act_code_present_o, deact_code_present_o} ==
    $past({act_match_i & act_detect_en_i, deact_match_i & deact_detect_en_i}, 2))
    else $error("pres");
  act_chg_a: assert property (
    act_change_o == (act_code_present_o != $past(act_code_present_o))) else $error("act chg");
  deact_chg_a: assert property (
    deact_change_o == (deact_code_present_o != $past(deact_code_present_o))) else $error("de chg");
  irq_clear_a: assert property (
    rd_i && addr_i == `LBC_STATUS_OFS |-> ##2 (!irq_o || act_change_o || deact_change_o))
    else $error("irq held");
  irq_cause_a: assert property (
    $rose(irq_o) |-> act_change_o || deact_change_o || $past(wr_i && addr_i == `LBC_ENABLE_OFS, 2))
    else $error("irq cause");
  stat_rsvd_a: assert property ($past(rd_i) |-> rdata_o[7:4] == 4'h0) else $error("rsvd");
  en_rsvd_a: assert property (
    $past(rd_i && addr_i == `LBC_ENABLE_OFS) |-> rdata_o[7:2] == 6'h00) else $error("en rsvd");
  idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("idle");
endmodule
bind loopback_code_irq loopback_code_irq_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

// file: loopback_code_interrupt_logic_bench.sv
`timescale 1ns/1ns
// directed and random traffic on the loopback code block
module loopback_code_interrupt_logic_bench;
  logic       ref_clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [1:0] send = 2'h0, en = 2'h0;
  logic       act_match_i, deact_match_i, act_code_present_o, deact_code_present_o;
  logic       act_change_o, deact_change_o, irq_o;
  wire logic  act_detect_en_i = en[1];
  wire logic  deact_detect_en_i = en[0];
  int         n_mismatch = 0, n_tests = 0;
  // 10 MHz clock
  always #50 ref_clk_i = ~ref_clk_i;
  remote_code_source u_far (.ref_clk_i, .send_i(send), .act_match_o(act_match_i),
    .deact_match_o(deact_match_i));
  loopback_code_irq u_dut (.*);
  task automatic check(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // single output pins: irq level and present copies
  task automatic check_pin(input logic got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t pin %b want %b", $time, got, exp);
    end
  endtask
  // status byte as software should see it: present above flags, reserved zero
  function automatic logic [7:0] status_of(input logic [1:0] pres, flg);
    return {4'h0, pres, flg};
  endfunction
  // one-cycle strobe; read data sits in the cycle after
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e, m = 8'hFF);
    bus(1'b0, a, 8'h00);
    check(rdata_o & m, e);
  endtask
  // far end switches codes, then the line settles
  task automatic drive(input logic [1:0] s, e);
    @(posedge ref_clk_i);
    send <= s;
    en   <= e;
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic close_out;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hA07C4232));
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
    bus(1'b1, 8'h21, 8'hFF);
    rd(8'h21, 8'h03);
    // each code: start, read clears flag, stop sets it again
    for (int c = 0; c < 2; c++) begin
      drive(2'(1 << c), 2'h3);
      check_pin(irq_o, 1'b1);
      check_pin(act_code_present_o, c == 1);
      check_pin(deact_code_present_o, c == 0);
      rd(8'h22, status_of(2'(1 << c), 2'(1 << c)));
      #200 check_pin(irq_o, 1'b0);
      rd(8'h22, status_of(2'(1 << c), 2'h0));
      drive(2'h0, 2'h3);
      check_pin(act_code_present_o | deact_code_present_o, 1'b0);
      rd(8'h22, status_of(2'h0, 2'(1 << c)));
    end
    // masked change, then unmask raises irq from the pending flag
    bus(1'b1, 8'h21, 8'h01);
    drive(2'h2, 2'h3);
    check_pin(irq_o, 1'b0);
    bus(1'b1, 8'h21, 8'h02);
    #100 check_pin(irq_o, 1'b1);
    drive(2'h3, 2'h1);
    rd(8'h22, 8'h07);
    bus(1'b1, 8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(8'h21, 8'h02);
    repeat (40) begin
      @(posedge ref_clk_i);
      send <= 2'($urandom);
      en   <= 2'($urandom);
    end
    #1 drive(send, en);
    rd(8'h22, status_of(send & en, 2'h0), 8'h0C);
    // both codes drop with flags pending; inputs idle before reset so nothing
    // stale is sampled across the release
    drive(2'h3, 2'h3);
    drive(2'h0, 2'h0);
    check_pin(irq_o, 1'b1);
    // mid-run reset wipes enables and pending flags
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
    check_pin(irq_o, 1'b0);
    close_out;
  end
endmodule
